//--- verification/iodio_field.sv
`timescale 1ns/1ns
// Field device: drives isolated inputs, reads outputs
module iodio_field
(
  input wire logic [15:0] out_pin_i,
  output wire logic [15:0] in_pin_o,
  output wire logic [15:0] seen_o
);
  // Logical levels asserted, set by the bench
  logic [15:0] drive_q = 16'h0000;
  assign in_pin_o = ~drive_q;
  assign seen_o = ~out_pin_i;
endmodule

//--- verification/iodio_props.sv
`timescale 1ns/1ns
// Port-level checks of the digital I/O block
module iodio_props
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [15:0] out_pin_o,
  input wire logic irq_o,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o
);
  // Single clock domain
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // Address and data taken together
  sequence s_wr_both;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  // Write data offered within the last three edges
  sequence s_wr_recent;
    $past(s_axi_wvalid_i) || $past(s_axi_wvalid_i, 2) || $past(s_axi_wvalid_i, 3);
  endsequence
  property p_out_reset; $rose(reset_n_i) |-> out_pin_o == 16'hFFFF && !irq_o; endproperty
  property p_out_change; $changed(out_pin_o) |-> s_wr_recent; endproperty
  property p_irq_fall; $fell(irq_o) |-> s_wr_recent; endproperty
  // Both halves held one cycle, then the answer registers
  property p_wr_resp; s_wr_both |=> ##1 s_axi_bvalid_o; endproperty
  property p_b_drop; s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o; endproperty
  property p_aw_block; s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o; endproperty
  property p_rd_resp; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o; endproperty
  property p_ar_block; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
  a_out_reset: assert property (p_out_reset) else $error("outputs not idle");
  a_out_change: assert property (p_out_change) else $error("pins moved alone");
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  a_b_drop: assert property (p_b_drop) else $error("bvalid held");
  a_aw_block: assert property (p_aw_block) else $error("write ready early");
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  a_ar_block: assert property (p_ar_block) else $error("arready early");
endmodule
bind iodio_top iodio_props u_props (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
  .out_pin_o(out_pin_o), .irq_o(irq_o), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o));

//--- verification/tb.sv
`timescale 1ns/1ns
module tb;
  // Clock, reset, bus drive
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] awa = 32'h0000_0000;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] ara = 32'h0000_0000;
  logic [3:0] ws = 4'hF;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bry = 1'b0;
  logic arv = 1'b0;
  logic rry = 1'b0;
  // Design answers
  wire awrdy, wrdy, bv, arrdy, rv, irq;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  wire [15:0] pout, pin, seen;
  int miscompares = 0;
  int samples_checked = 0;

  iodio_top uut (.ref_clk_i(clk), .reset_n_i(rst_n), .in_pin_i(pin), .out_pin_o(pout),
    .irq_o(irq), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awrdy),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
    .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_araddr_i(ara),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arrdy), .s_axi_rdata_o(rdat),
    .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry));
  iodio_field fld (.out_pin_i(pout), .in_pin_o(pin), .seen_o(seen));

  // 250 MHz clock
  initial forever #2 clk = ~clk;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bus write; readies may come in either order
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
    input logic [1:0] er = 2'h0);
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awrdy === 1'b1) awv <= 1'b0;
      if (wrdy === 1'b1) wv <= 1'b0;
    end
    while (bv !== 1'b1);
    bry <= 1'b0;
    chk("bresp", 32'(er), 32'(br));
    // Spare edge so no strobe toggles twice at once
    @(posedge clk);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arrdy === 1'b1) arv <= 1'b0;
    end
    while (rv !== 1'b1);
    rry <= 1'b0;
    chk("rdata", e, rdat);
    chk("rresp", 32'(er), 32'(rr));
    @(posedge clk);
  endtask

  task automatic sc_reset;
    for (int i = 0; i < 6; i++)
    begin
      rd(32'(4 * i), 32'h0000_0000);
    end
    rd(32'h0000_0018, 32'h0000_0000, 2'h2);
    wr(32'h0000_001C, 32'h0000_FFFF, 4'hF, 2'h2);
    chk("out_pin", 32'h0000_FFFF, 32'(pout));
    chk("irq", 32'h0000_0000, 32'(irq));
  endtask

  task automatic sc_out;
    wr(5'h04, 32'h0000_A5C3);
    cyc(2);
    chk("field_seen", 32'h0000_A5C3, 32'(seen));
    chk("out_pin", 32'h0000_5A3C, 32'(pout));
    // Low byte strobe only
    wr(5'h04, 32'h0000_00FF, 4'h1);
    rd(5'h04, 32'h0000_A5FF);
    wr(5'h00, 32'h0000_FFFF);
    rd(5'h00, 32'h0000_0000);
  endtask

  task automatic sc_irq;
    wr(5'h08, 32'h0000_FFFF);
    wr(5'h0C, 32'h0000_00FF);
    fld.drive_q <= 16'hFFFF;
    cyc(10);
    rd(5'h00, 32'h0000_FFFF);
    rd(5'h10, 32'h0000_00FF);
    chk("irq", 32'h0000_0001, 32'(irq));
    wr(5'h10, 32'h0000_FFFF);
    cyc(3);
    chk("irq", 32'h0000_0000, 32'(irq));
    fld.drive_q <= 16'h0000;
    cyc(10);
    rd(5'h10, 32'h0000_FF00);
    // Masking hides set bits
    wr(5'h08, 32'h0000_00FF);
    cyc(3);
    chk("irq", 32'h0000_0000, 32'(irq));
    wr(5'h10, 32'h0000_FFFF);
    wr(5'h0C, 32'h0000_FFFF);
    fld.drive_q <= 16'hFFFF;
    cyc(10);
    rd(5'h10, 32'h0000_00FF);
    wr(5'h10, 32'h0000_FFFF);
  endtask

  // Chatter shorter than one tick is rejected
  task automatic sc_filter;
    wr(5'h14, 32'h0000_0001);
    repeat (3)
    begin
      fld.drive_q <= 16'hFFF7;
      cyc(20);
      fld.drive_q <= 16'hFFFF;
      cyc(20);
    end
    rd(5'h00, 32'h0000_FFFF);
    fld.drive_q <= 16'hFFF7;
    cyc(250);
    rd(5'h00, 32'h0000_FFF7);
  endtask

  // Reset in mid-run returns pins and registers to idle
  task automatic sc_rst;
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(2);
    chk("out_pin", 32'h0000_FFFF, 32'(pout));
    chk("irq", 32'h0000_0000, 32'(irq));
    rd(5'h04, 32'h0000_0000);
    rd(5'h14, 32'h0000_0000);
  endtask

  task automatic results;
    $display("compared %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    cyc(5);
    rst_n <= 1'b1;
    cyc(2);
    sc_reset();
    sc_out();
    sc_irq();
    sc_filter();
    sc_rst();
    results();
  end

  // Run needs about 520 cycles; generous margin
  initial
  begin
    #20000;
    miscompares++;
    results();
  end
endmodule

//--- verilog/iodio_filter.v
`timescale 1ns/1ns
`include "iodio_regs.vh"

// One-channel synchroniser and stability filter
module iodio_filter
(
  input wire ref_clk_i,
  input wire reset_n_i,
  input wire pin_i,
  input wire tick_i,
  input wire [15:0] limit_i,
  output wire level_o
);

  // Two-stage synchroniser; first stage feeds only the second
  reg sync1_q;
  reg sync2_q;
  // Accepted logical level
  reg level_q;
  // Stability counter in filter ticks
  reg [15:0] cnt_q;

  always @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end
    else
    begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
    end
  end

  always @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      level_q <= 1'b0;
      cnt_q <= `IODIO_RST_16;
    end
    else if (sync2_q == level_q)
    begin
      // Matches accepted value, restart count
      cnt_q <= `IODIO_RST_16;
    end
    else if (cnt_q >= limit_i)
    begin
      // Stable long enough; zero limit means no filtering
      level_q <= sync2_q;
      cnt_q <= `IODIO_RST_16;
    end
    else if (tick_i)
    begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign level_o = level_q;

endmodule

//--- verilog/iodio_regs.vh
`ifndef IODIO_REGS_VH
`define IODIO_REGS_VH

// Register byte addresses
`define IODIO_ADDR_IN      5'h00
`define IODIO_ADDR_OUT     5'h04
`define IODIO_ADDR_IRQ_EN  5'h08
`define IODIO_ADDR_EDGE    5'h0C
`define IODIO_ADDR_STATUS  5'h10
`define IODIO_ADDR_FILT    5'h14
// Address decode width (32-byte window)
`define IODIO_AW           5
// Reset values
`define IODIO_RST_16       16'h0000
`define IODIO_RST_FILT     4'h0
`define IODIO_FILT_W       4
// AXI responses
`define IODIO_RESP_OKAY    2'b00
`define IODIO_RESP_SLVERR  2'b10
// Filter tick period: 250 ns target, integer division gives 62 cycles
`define IODIO_TICK_NS      250
`define IODIO_CLK_NS       4
`define IODIO_TICK_CYC     (`IODIO_TICK_NS / `IODIO_CLK_NS)
`define IODIO_TICK_W       6
`define IODIO_CNT_W        16

`endif

//--- verilog/iodio_top.v
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`include "iodio_regs.vh"

// Behaviour
// - Sixteen inputs, each an interrupt source
// - Sixteen outputs set by host data
// - Per-channel interrupt enable gates requests
// - Per-channel rising or falling edge select
// - All channels merged onto one INTA
// - Software-set digital filter on every input
// - Negative logic: logical one is low
module iodio_top
(
  input wire ref_clk_i,
  input wire reset_n_i,
  // Field inputs, terminal level (high = logical 0)
  input wire [15:0] in_pin_i,
  // Field outputs, terminal level (low = logical 1)
  output reg [15:0] out_pin_o,
  // Level interrupt toward host (INTA)
  output reg irq_o,
  // AXI4-Lite slave
  input wire [31:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [31:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i
);

  // Output data, logical value
  reg [15:0] out_data_q;
  // Interrupt enable mask, one per channel
  reg [15:0] irq_en_q;
  // Edge select: 1 = rising, 0 = falling (logical level)
  reg [15:0] edge_sel_q;
  // Sticky interrupt status
  reg [15:0] status_q;
  reg [15:0] status_d;
  // Filter exponent: 2^n ticks of stability, 0 = off
  reg [`IODIO_FILT_W-1:0] filt_q;
  // Previous filtered level for edge detection
  reg [15:0] prev_q;
  // Filter time base
  reg [`IODIO_TICK_W-1:0] tick_cnt_q;
  reg tick_q;
  // Captured write address/data
  reg aw_have_q;
  reg w_have_q;
  reg [`IODIO_AW-1:0] aw_addr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  // Filtered logical levels
  wire [15:0] level_w;
  // Logical input: inverted terminal level
  wire [15:0] in_log_w;
  // Edge events per channel
  wire [15:0] rise_w;
  wire [15:0] fall_w;
  wire [15:0] event_w;
  // Filter stability limit in ticks
  wire [15:0] limit_w;
  // Write fires this cycle
  wire wr_go_w;
  // Write strobes for clearing status
  wire [15:0] clr_w;
  // Write lane mask of the low half-word
  wire [15:0] mask_w;

  assign in_log_w = ~in_pin_i;

  // Limit grows in powers of two; keeps the field small
  assign limit_w = (filt_q == `IODIO_RST_FILT) ? `IODIO_RST_16 :
                   (16'h0001 << filt_q);

  // Filter time base tick generator
  always @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      tick_cnt_q <= {`IODIO_TICK_W{1'b0}};
      tick_q <= 1'b0;
    end
    else if (tick_cnt_q == `IODIO_TICK_CYC - 1)
    begin
      tick_cnt_q <= {`IODIO_TICK_W{1'b0}};
      tick_q <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_ch
      iodio_filter u_filt
      (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .pin_i(in_log_w[gi]),
        .tick_i(tick_q),
        .limit_i(limit_w),
        .level_o(level_w[gi])
      );
    end
  endgenerate

  // Previous level register for edges
  always @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      prev_q <= `IODIO_RST_16;
    end
    else
    begin
      prev_q <= level_w;
    end
  end

  assign rise_w = level_w & ~prev_q;
  assign fall_w = ~level_w & prev_q;
  assign event_w = irq_en_q & ((edge_sel_q & rise_w) | (~edge_sel_q & fall_w));

  assign wr_go_w = aw_have_q && w_have_q && !s_axi_bvalid_o;
  assign mask_w = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign clr_w = (wr_go_w && aw_addr_q == `IODIO_ADDR_STATUS) ?
                 (wdata_q[15:0] & mask_w) : `IODIO_RST_16;

  // Status next value; set wins over clear
  always @*
  begin
    status_d = (status_q & ~clr_w) | event_w;
  end

  // Sticky status and merged interrupt
  always @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      status_q <= `IODIO_RST_16;
      irq_o <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      irq_o <= |(status_d & irq_en_q);
    end
  end

  always @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      // Logical 0 = high terminal, outputs off
      out_pin_o <= ~`IODIO_RST_16;
    end
    else
    begin
      out_pin_o <= ~out_data_q;
    end
  end

  // Write address and data capture, either order
  always @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= {`IODIO_AW{1'b0}};
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
    end
    else
    begin
      // Each ready only while its own channel holds nothing
      s_axi_awready_o <= !aw_have_q && !(s_axi_awvalid_i && s_axi_awready_o);
      s_axi_wready_o <= !w_have_q && !(s_axi_wvalid_i && s_axi_wready_o);
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr_i[`IODIO_AW-1:0];
      end
      else if (wr_go_w)
      begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      else if (wr_go_w)
      begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Register writes and write response
  always @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      out_data_q <= `IODIO_RST_16;
      irq_en_q <= `IODIO_RST_16;
      edge_sel_q <= `IODIO_RST_16;
      filt_q <= `IODIO_RST_FILT;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `IODIO_RESP_OKAY;
    end
    else
    begin
      if (s_axi_bvalid_o && s_axi_bready_i)
      begin
        s_axi_bvalid_o <= 1'b0;
      end
      if (wr_go_w)
      begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= `IODIO_RESP_OKAY;
        case (aw_addr_q)
          `IODIO_ADDR_OUT:
          begin
            out_data_q <= (out_data_q & ~mask_w) | (wdata_q[15:0] & mask_w);
          end
          `IODIO_ADDR_IRQ_EN:
          begin
            irq_en_q <= (irq_en_q & ~mask_w) | (wdata_q[15:0] & mask_w);
          end
          `IODIO_ADDR_EDGE:
          begin
            edge_sel_q <= (edge_sel_q & ~mask_w) | (wdata_q[15:0] & mask_w);
          end
          `IODIO_ADDR_FILT:
          begin
            if (wstrb_q[0])
            begin
              filt_q <= wdata_q[`IODIO_FILT_W-1:0];
            end
          end
          // Input and status take no stored write
          `IODIO_ADDR_IN, `IODIO_ADDR_STATUS:
          begin
            s_axi_bresp_o <= `IODIO_RESP_OKAY;
          end
          default:
          begin
            // Unmapped offset
            s_axi_bresp_o <= `IODIO_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // Read channel: one read at a time, answer next cycle
  always @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `IODIO_RESP_OKAY;
    end
    else
    begin
      s_axi_arready_o <= !s_axi_rvalid_o && !(s_axi_arvalid_i && s_axi_arready_o);
      if (s_axi_rvalid_o && s_axi_rready_i)
      begin
        s_axi_rvalid_o <= 1'b0;
      end
      if (s_axi_arvalid_i && s_axi_arready_o)
      begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= `IODIO_RESP_OKAY;
        case (s_axi_araddr_i[`IODIO_AW-1:0])
          `IODIO_ADDR_IN:
          begin
            // Filtered logical input state
            s_axi_rdata_o <= {16'h0000, level_w};
          end
          `IODIO_ADDR_OUT:
          begin
            s_axi_rdata_o <= {16'h0000, out_data_q};
          end
          `IODIO_ADDR_IRQ_EN:
          begin
            s_axi_rdata_o <= {16'h0000, irq_en_q};
          end
          `IODIO_ADDR_EDGE:
          begin
            s_axi_rdata_o <= {16'h0000, edge_sel_q};
          end
          `IODIO_ADDR_STATUS:
          begin
            s_axi_rdata_o <= {16'h0000, status_q};
          end
          `IODIO_ADDR_FILT:
          begin
            s_axi_rdata_o <= {28'h000_0000, filt_q};
          end
          default:
          begin
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= `IODIO_RESP_SLVERR;
          end
        endcase
      end
    end
  end

endmodule
